// >>> rtl/reset_mode_cfg.svh
// What this block does
// - sample data, mode, clock, breakpoint pins in reset
// - mode pin high, data1 low: 16-bit bus
// - data2 picks request/codes, data3 gives address19
// - data6..4 load chip-select assign fields 3..1
// - data15 low or shadow set stops flash
// - 8-bit mode: low data byte is port
// - 8-bit mode: no emulator, fixed pin functions
// - 8-bit mode: data8, data9 still choose ports
// - mode pin low: single chip, all ports
// - data10, data1 low, mode high: emulator mode
// - emulator mode maps port registers externally
// - port C and F registers stay internal
// - emulator select on strobe fall, mapped access
// - no internal answer; mapped access three cycles
// - data1,10,13 low: ROM emulation, ROM select
// - ROM emulation: ROM withholds ack, external cycle
// - ROM select held high, flash lacks emulation
// - clock pin high synthesizer, low crystal input
`ifndef RESET_MODE_CFG_SVH
`define RESET_MODE_CFG_SVH
// data bus bit positions sampled at reset
`define SEL_MODE_BIT 1
`define SEL_REQ_BIT 2
`define SEL_A19_BIT 3
`define SEL_CSPA_LO 4
`define SEL_CSPA_HI 6
`define SEL_A23_BIT 7
`define SEL_PE_BIT 8
`define SEL_PF_BIT 9
`define SEL_EMU_BIT 10
`define SEL_RSVD_BIT 11
`define SEL_ROM_BIT 13
`define SEL_STOP_BIT 15
// reset values of sampled pins (data pins pulled up)
`define DATA_RESET_VAL 16'hffff
// cycles an externally mapped access takes
`define EXT_ACCESS_CYCLES 2'h3
`endif

// >>> rtl/reset_mode_pkg.sv
package reset_mode_pkg;
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_EXP8 = 2'b01,
    MODE_EXP16 = 2'b11
  } op_mode_t;
  typedef enum logic [3:0] {
    REG_PA_DATA = 4'h0, REG_PA_DIR = 4'h1, REG_PB_DATA = 4'h2, REG_PB_DIR = 4'h3,
    REG_PE_DATA = 4'h4, REG_PE_DIR = 4'h5, REG_PE_ASSIGN = 4'h6, REG_PG_DATA = 4'h7,
    REG_PG_DIR = 4'h8, REG_PH_DATA = 4'h9, REG_PH_DIR = 4'ha, REG_PC_DATA = 4'hb,
    REG_PF_DATA = 4'hc, REG_PF_DIR = 4'hd, REG_PF_ASSIGN = 4'he, REG_NONE = 4'hf
  } port_reg_t;
  typedef struct packed {
    op_mode_t mode;
    logic bus_request_sel;   // 1: request pin, 0: chip_select_zero
    logic func_code_sel;     // 1: function codes, 0: chip selects
    logic port_c_sel;        // function code pins as port C
    logic addr19_sel;
    logic addr23_sel;
    logic port_e_sel;        // 1: port E, 0: bus strobes
    logic port_f_sel;        // 1: port F, 0: clock and interrupt pins
    logic emulator_en;
    logic rom_emu_en;
    logic background_en;
    logic reserved_func;
    logic addr_bus_en;
    logic data_hi_bus_en;
    logic data_lo_bus_en;
    logic ports_ab_en;
    logic port_g_en;
    logic port_h_en;
    logic [2:0] chip_select_assign_reg1_fld;
    logic flash_stop;
    logic synth_clock_en;
    logic crystal_clock_sel;
  } pin_cfg_t;
endpackage

// >>> rtl/reset_mode_pin_config.sv
`timescale 1ns/100ps
`default_nettype none
`include "reset_mode_cfg.svh"
module reset_mode_pin_config #(
  parameter bit ROM_EMU_SUPPORTED = 1'b0
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [15:0] data_pins_in,
  input wire logic bus_error_mode_pin_n_in,
  input wire logic clock_source_select_pin_in,
  input wire logic breakpoint_pin_n_in,
  input wire logic flash_stop_shadow_in,
  input wire logic address_strobe_pin_n_in,
  input wire logic reg_access_valid_in,
  input wire reset_mode_pkg::port_reg_t reg_access_sel_in,
  input wire logic rom_range_access_in,
  output reset_mode_pkg::pin_cfg_t pin_cfg_out,
  output logic config_locked_out,
  output logic internal_respond_out,
  output logic emulator_chip_select_n_out,
  output logic ext_access_done_out,
  output logic rom_ack_inhibit_out,
  output logic ext_bus_cycle_req_out,
  output logic rom_emulation_chip_select_n_out
);
  import reset_mode_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    pin_cfg_t cfg;
    logic locked;
    logic strobe_n_prev;
    logic cse_n;
    logic [1:0] cse_cnt;
    logic done;
    logic ext_req;
    logic csm_n;
  } state_t;

  state_t st_q;
  state_t st_d;

  // registers answered by the external port replacement logic
  function automatic logic ext_mapped(input port_reg_t r);
    case (r)
      REG_PA_DATA, REG_PA_DIR, REG_PB_DATA, REG_PB_DIR,
      REG_PE_DATA, REG_PE_DIR, REG_PE_ASSIGN,
      REG_PG_DATA, REG_PG_DIR, REG_PH_DATA, REG_PH_DIR: ext_mapped = 1'b1;
      default: ext_mapped = 1'b0; // port C and F stay internal
    endcase
  endfunction

  // ----------------------------------------
  // decode of the strap levels
  // ----------------------------------------
  function automatic pin_cfg_t decode(input logic [15:0] d, input logic bus_error_mode_pin_n,
                                      input logic clock_source_select_pin, input logic breakpoint_pin_n,
                                      input logic shadow);
    pin_cfg_t c;
    c = '0;
    // straps common to every mode
    c.background_en = ~breakpoint_pin_n;
    c.reserved_func = ~d[`SEL_RSVD_BIT];
    c.chip_select_assign_reg1_fld = d[`SEL_CSPA_HI:`SEL_CSPA_LO];
    c.flash_stop = ~d[`SEL_STOP_BIT] | shadow;
    c.synth_clock_en = clock_source_select_pin;
    c.crystal_clock_sel = ~clock_source_select_pin;
    if (!bus_error_mode_pin_n) begin
      // single chip: every port, no external data path
      c.mode = MODE_SINGLE;
      c.ports_ab_en = 1'b1;
      c.port_g_en = 1'b1;
      c.port_h_en = 1'b1;
      c.port_c_sel = 1'b1;
      c.port_e_sel = 1'b1;
      c.port_f_sel = 1'b1;
    end else if (d[`SEL_MODE_BIT]) begin
      // 8-bit: low byte is port, fixed pin functions
      c.mode = MODE_EXP8;
      c.addr_bus_en = 1'b1;
      c.data_hi_bus_en = 1'b1;
      c.port_h_en = 1'b1;
      c.port_e_sel = ~d[`SEL_PE_BIT];
      c.port_f_sel = ~d[`SEL_PF_BIT];
    end else begin
      // 16-bit: low level on a select bit picks the alternate
      c.mode = MODE_EXP16;
      c.addr_bus_en = 1'b1;
      c.data_hi_bus_en = 1'b1;
      c.data_lo_bus_en = 1'b1;
      c.bus_request_sel = ~d[`SEL_REQ_BIT];
      c.func_code_sel = ~d[`SEL_REQ_BIT];
      c.addr19_sel = ~d[`SEL_A19_BIT];
      c.addr23_sel = ~d[`SEL_A23_BIT];
      c.port_e_sel = ~d[`SEL_PE_BIT];
      c.port_f_sel = ~d[`SEL_PF_BIT];
      c.emulator_en = ~d[`SEL_EMU_BIT];
      c.rom_emu_en = ~d[`SEL_EMU_BIT] & ~d[`SEL_ROM_BIT];
    end
    decode = c;
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  // strobe edge and mapped-register decode, shared with the checks below
  logic strobe_fall;
  logic mapped_hit;
  always_comb begin
    st_d = st_q;
    strobe_fall = st_q.strobe_n_prev & ~address_strobe_pin_n_in;
    mapped_hit = reg_access_valid_in & st_q.cfg.emulator_en & ext_mapped(reg_access_sel_in);
    st_d.strobe_n_prev = address_strobe_pin_n_in;
    st_d.done = 1'b0;
    st_d.ext_req = 1'b0;
    if (!rst_n_in) begin
      // keep following the straps until release; last sample wins
      st_d.cfg = decode(data_pins_in, bus_error_mode_pin_n_in, clock_source_select_pin_in,
                        breakpoint_pin_n_in, flash_stop_shadow_in);
      st_d.locked = 1'b0;
      st_d.strobe_n_prev = 1'b1;
      st_d.cse_n = 1'b1;
      st_d.cse_cnt = 2'h0;
      st_d.csm_n = 1'b1;
    end else begin
      // configuration frozen until the next reset
      st_d.locked = 1'b1;
      // emulator select opens on strobe fall, counts the access
      if (st_q.cse_n) begin
        if (strobe_fall && mapped_hit) begin
          st_d.cse_n = 1'b0;
          st_d.cse_cnt = 2'h1;
        end
      end else begin
        if (st_q.cse_cnt == `EXT_ACCESS_CYCLES) begin
          st_d.cse_n = 1'b1;
          st_d.cse_cnt = 2'h0;
          st_d.done = 1'b1;
        end else begin
          st_d.cse_cnt = st_q.cse_cnt + 2'h1;
        end
      end
      // ROM emulation: every ROM range access goes out
      if (st_q.cfg.rom_emu_en && strobe_fall && rom_range_access_in) begin
        st_d.ext_req = 1'b1;
      end
      // flash cannot emulate, so the select stays high unless supported
      st_d.csm_n = ~(ROM_EMU_SUPPORTED & st_q.cfg.rom_emu_en & rom_range_access_in
                     & ~address_strobe_pin_n_in);
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // no reset term here: the synchronous reset lives in the next-state logic
  always_ff @(posedge clk_in) begin
    st_q <= st_d;
  end

  // outputs straight from flops, handshake term combinational
  assign pin_cfg_out = st_q.cfg;
  assign config_locked_out = st_q.locked;
  assign emulator_chip_select_n_out = st_q.cse_n;
  assign ext_access_done_out = st_q.done;
  assign rom_ack_inhibit_out = st_q.cfg.rom_emu_en;
  assign ext_bus_cycle_req_out = st_q.ext_req;
  assign rom_emulation_chip_select_n_out = st_q.csm_n;
  // device stays silent on externally mapped registers
  assign internal_respond_out = reg_access_valid_in & ~mapped_hit;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence mapped_fall_s;
    st_q.cse_n && strobe_fall && mapped_hit;
  endsequence
  sequence cse_window_s;
    !emulator_chip_select_n_out [*3] ##1 emulator_chip_select_n_out && ext_access_done_out;
  endsequence

  a_cse_three_cycles: assert property (mapped_fall_s |=> cse_window_s)
    else $error("emulator select window not three cycles");
  a_cse_needs_emu: assert property ($fell(emulator_chip_select_n_out)
                                    |-> pin_cfg_out.emulator_en)
    else $error("emulator select outside emulator mode");
  a_no_internal_answer: assert property (reg_access_valid_in && pin_cfg_out.emulator_en
      && ext_mapped(reg_access_sel_in) |-> !internal_respond_out)
    else $error("internal answer on mapped register");
  a_port_cf_internal: assert property (reg_access_valid_in
      && reg_access_sel_in inside {REG_PC_DATA, REG_PF_DATA, REG_PF_DIR, REG_PF_ASSIGN}
      |-> internal_respond_out)
    else $error("port C or F not answered internally");
  a_cfg_held: assert property (config_locked_out |=> $stable(pin_cfg_out))
    else $error("configuration changed after release");
  a_exp8_no_emu: assert property (pin_cfg_out.mode == MODE_EXP8
      |-> !pin_cfg_out.emulator_en
      && !pin_cfg_out.bus_request_sel && !pin_cfg_out.addr19_sel
      && !pin_cfg_out.addr23_sel && pin_cfg_out.port_h_en)
    else $error("8-bit mode pin functions wrong");
  a_single_ports: assert property (pin_cfg_out.mode == MODE_SINGLE
      |-> pin_cfg_out.ports_ab_en
      && pin_cfg_out.port_e_sel && pin_cfg_out.port_f_sel && !pin_cfg_out.addr_bus_en
      && !pin_cfg_out.data_hi_bus_en)
    else $error("single chip ports not all selected");
  a_clock_source: assert property (pin_cfg_out.synth_clock_en
                                   != pin_cfg_out.crystal_clock_sel)
    else $error("clock source selection ambiguous");
  a_rom_select_high: assert property (!ROM_EMU_SUPPORTED
      |-> rom_emulation_chip_select_n_out)
    else $error("ROM select driven low");
  a_rom_ext_cycle: assert property (pin_cfg_out.rom_emu_en && strobe_fall
      && rom_range_access_in |=> ext_bus_cycle_req_out)
    else $error("ROM access without external cycle");
  a_rom_emu_cause: assert property (pin_cfg_out.rom_emu_en |-> pin_cfg_out.emulator_en
      && pin_cfg_out.mode == MODE_EXP16)
    else $error("ROM emulation without emulator mode");

  // ----------------------------------------
  // further checks on straps and pulses
  // ----------------------------------------
  // reset must keep every select and pulse quiet, even while straps move
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n_in
      |=> !config_locked_out && emulator_chip_select_n_out && rom_emulation_chip_select_n_out
      && !ext_access_done_out && !ext_bus_cycle_req_out)
    else $error("select or pulse active in reset");

  // lock follows one edge after release and then stays
  a_lock_follows: assert property (!config_locked_out |=> config_locked_out)
    else $error("configuration not locked after release");

  // 16-bit: full bus, no ports A/B, G or H
  a_exp16_buses: assert property (pin_cfg_out.mode == MODE_EXP16
      |-> pin_cfg_out.addr_bus_en && pin_cfg_out.data_hi_bus_en && pin_cfg_out.data_lo_bus_en
      && !pin_cfg_out.ports_ab_en && !pin_cfg_out.port_g_en && !pin_cfg_out.port_h_en)
    else $error("16-bit mode still offers shared ports");

  // one strap bit drives both the request and the function-code picks
  a_req_code_pair: assert property (pin_cfg_out.bus_request_sel
      == pin_cfg_out.func_code_sel)
    else $error("request and function-code picks disagree");

  // function codes only exist with the full bus
  a_codes_exp16: assert property (pin_cfg_out.func_code_sel
      |-> pin_cfg_out.mode == MODE_EXP16)
    else $error("function codes outside 16-bit mode");

  // 8-bit: low data byte off the bus, fixed select functions
  a_exp8_data_port: assert property (pin_cfg_out.mode == MODE_EXP8
      |-> !pin_cfg_out.data_lo_bus_en && pin_cfg_out.data_hi_bus_en && pin_cfg_out.addr_bus_en
      && !pin_cfg_out.func_code_sel && !pin_cfg_out.port_c_sel && !pin_cfg_out.rom_emu_en)
    else $error("8-bit mode bus or select functions wrong");

  // single chip: ports G, H and C present, no emulation of any kind
  a_single_no_emu: assert property (pin_cfg_out.mode == MODE_SINGLE
      |-> pin_cfg_out.port_g_en && pin_cfg_out.port_h_en && pin_cfg_out.port_c_sel
      && !pin_cfg_out.data_lo_bus_en && !pin_cfg_out.emulator_en && !pin_cfg_out.rom_emu_en)
    else $error("single chip ports or emulation wrong");

  // without the emulator strap the select never moves
  a_cse_idle_no_emu: assert property (!pin_cfg_out.emulator_en
      |-> emulator_chip_select_n_out)
    else $error("emulator select low outside emulator mode");

  // the select only falls after a strobe fall on a mapped register
  a_cse_from_fall: assert property ($fell(emulator_chip_select_n_out)
      |-> $past(strobe_fall && mapped_hit))
    else $error("emulator select fell without a mapped access");

  // the access counter runs only while the select is low
  a_cse_count_live: assert property (!emulator_chip_select_n_out
      |-> st_q.cse_cnt != 2'h0)
    else $error("access counter idle while select low");
  a_cse_count_idle: assert property (emulator_chip_select_n_out
      |-> st_q.cse_cnt == 2'h0)
    else $error("access counter running while select high");

  // an internal answer needs an access in the first place
  a_respond_valid: assert property (internal_respond_out |-> reg_access_valid_in)
    else $error("internal answer without an access");

  // done and external cycle request are single-cycle pulses
  sequence done_pulse_s;
    ext_access_done_out ##1 !ext_access_done_out;
  endsequence
  a_done_pulse: assert property (ext_access_done_out |-> done_pulse_s)
    else $error("access done pulse too long");

  sequence req_pulse_s;
    ext_bus_cycle_req_out ##1 !ext_bus_cycle_req_out;
  endsequence
  a_req_pulse: assert property (ext_bus_cycle_req_out |-> req_pulse_s)
    else $error("external cycle request too long");

  // the acknowledge inhibit is a level tied to the rom emulation strap
  a_inhibit_level: assert property (rom_ack_inhibit_out == pin_cfg_out.rom_emu_en)
    else $error("acknowledge inhibit not following rom emulation");
endmodule // reset_mode_pin_config
`default_nettype wire

// >>> bench/port_replacement_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// external port replacement access maker
// ----------------------------------------
module port_replacement_model (
  input wire logic clk_in,
  input wire logic go_in,
  input wire reset_mode_pkg::port_reg_t sel_in,
  input wire logic rom_in,
  output var logic strobe_n_out,
  output var logic valid_out,
  output var reset_mode_pkg::port_reg_t sel_out,
  output var logic rom_out,
  output var logic busy_out
);
  import reset_mode_pkg::*;
  initial begin
    strobe_n_out = 1'b1;
    valid_out = 1'b0;
    sel_out = REG_NONE;
    rom_out = 1'b0;
    busy_out = 1'b0;
  end
  // strobe held past the three-cycle access so the select can finish
  always @(negedge clk_in) begin
    if (go_in && !busy_out) begin
      busy_out <= 1'b1;
      strobe_n_out <= 1'b0;
      valid_out <= 1'b1;
      sel_out <= sel_in;
      rom_out <= rom_in;
      repeat (5) @(negedge clk_in);
      strobe_n_out <= 1'b1;
      valid_out <= 1'b0;
      sel_out <= REG_NONE; // released select names nothing
      rom_out <= 1'b0;
      busy_out <= 1'b0;
    end
  end
endmodule // port_replacement_model
`default_nettype wire

// >>> bench/reset_mode_pin_config_tb.sv
`timescale 1ns/100ps
`default_nettype none
module reset_mode_pin_config_tb;
  import reset_mode_pkg::*;
  logic clk_in = 0, rst_n_in = 0, ber_n = 1, clk_sel = 1, breakpoint_pin_n = 1, shadow = 0, go = 0;
  logic strobe_n, valid, rom_w, busy, lock_p = 0;
  logic locked, respond, cse_n, done, inhibit, ext_req, csm_n;
  logic [15:0] data = 16'hffff, dd;
  logic [3:0] t;
  port_reg_t sel_w;
  pin_cfg_t cfg, e;
  integer errors = 0, num_checks = 0, seed = 32'hf688, cnt = 0, i;
  logic [31:0] notes[$];
  always #20 clk_in = ~clk_in;
  reset_mode_pin_config uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .data_pins_in(data),
    .bus_error_mode_pin_n_in(ber_n), .clock_source_select_pin_in(clk_sel),
    .breakpoint_pin_n_in(breakpoint_pin_n), .flash_stop_shadow_in(shadow),
    .address_strobe_pin_n_in(strobe_n), .reg_access_valid_in(valid),
    .reg_access_sel_in(sel_w), .rom_range_access_in(rom_w), .pin_cfg_out(cfg),
    .config_locked_out(locked), .internal_respond_out(respond),
    .emulator_chip_select_n_out(cse_n), .ext_access_done_out(done),
    .rom_ack_inhibit_out(inhibit), .ext_bus_cycle_req_out(ext_req),
    .rom_emulation_chip_select_n_out(csm_n));
  port_replacement_model port_replacement_unit (.clk_in(clk_in), .go_in(go), .sel_in(REG_PA_DATA),
    .rom_in(1'b1), .strobe_n_out(strobe_n), .valid_out(valid), .sel_out(sel_w),
    .rom_out(rom_w), .busy_out(busy));
  // ----------------------------------------
  // reference decode and helpers
  // ----------------------------------------
  // bus-only selects are zeroed outside 16-bit mode, where they carry no meaning
  function automatic logic [24:0] proj(pin_cfg_t c);
    return {c.mode, c.emulator_en, c.rom_emu_en, c.port_e_sel, c.port_f_sel, c.addr_bus_en,
      c.data_hi_bus_en, c.data_lo_bus_en, c.ports_ab_en, c.port_g_en, c.port_h_en,
      c.port_c_sel, c.chip_select_assign_reg1_fld,
      c.flash_stop, c.synth_clock_en, c.crystal_clock_sel, c.background_en,
      c.reserved_func, (c.mode == MODE_EXP16) ? {c.addr19_sel, c.addr23_sel,
      c.bus_request_sel, c.func_code_sel} : 4'h0};
  endfunction
  function automatic pin_cfg_t want(logic [15:0] d);
    pin_cfg_t w;
    logic x16;
    w = '0;
    w.mode = !ber_n ? MODE_SINGLE : (d[1] ? MODE_EXP8 : MODE_EXP16);
    x16 = (w.mode == MODE_EXP16);
    w.emulator_en = x16 & !d[10];
    w.rom_emu_en = x16 & !d[10] & !d[13];
    w.port_e_sel = !ber_n | !d[8];
    w.port_f_sel = !ber_n | !d[9];
    w.addr_bus_en = ber_n;
    w.data_hi_bus_en = ber_n;
    w.port_g_en = !ber_n;
    w.port_c_sel = !ber_n;
    w.func_code_sel = !d[2];
    w.data_lo_bus_en = x16;
    w.ports_ab_en = !ber_n;
    w.port_h_en = !x16;
    w.chip_select_assign_reg1_fld = d[6:4];
    w.flash_stop = !d[15] | shadow;
    w.synth_clock_en = clk_sel;
    w.crystal_clock_sel = !clk_sel;
    w.background_en = !breakpoint_pin_n;
    w.reserved_func = !d[11];
    w.addr19_sel = !d[3];
    w.addr23_sel = !d[7];
    w.bus_request_sel = !d[2];
    return w;
  endfunction
  task automatic chk(logic [31:0] a, logic [31:0] b);
    num_checks++;
    if (a !== b) begin
      errors++;
      $display("[FAIL] %0t got %h want %h", $time, a, b);
    end
  endtask
  task automatic take(logic [31:0] a);
    if (notes.size() == 0) begin
      errors++;
      $display("[FAIL] %0t unexpected result %h", $time, a);
    end else begin
      chk(a, notes.pop_front());
    end
  endtask
  task tally_and_finish;
    if (errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------
  // result watcher: lock, rom cycle pulse, select width
  // ----------------------------------------
  always @(negedge clk_in) begin
    lock_p <= locked;
    if (locked === 1'b1 && lock_p !== 1'b1) take(32'(proj(cfg)));
    if (ext_req === 1'b1) take(32'h1);
    if (cse_n === 1'b0) cnt <= cnt + 1;
    else if (cnt != 0) begin
      take(cnt);
      chk(32'(done), 32'h1);
      cnt <= 0;
    end
  end
  // ----------------------------------------
  // straps per mode table, then one mapped rom-range access
  // ----------------------------------------
  initial begin
    fork
      begin
        #100000;
        errors++;
        tally_and_finish;
      end
    join_none
    for (i = 0; i < 10; i++) begin
      rst_n_in <= 1'b0;
      t = (i < 8) ? 4'(32'h0c8a9bf7 >> (i * 4)) : 4'($random(seed));
      dd = 16'($random(seed));
      dd[11] = 1'b1;
      dd[1] = t[2];
      dd[10] = t[1];
      dd[13] = t[0];
      data <= dd;
      ber_n <= t[3];
      clk_sel <= 1'($random(seed));
      breakpoint_pin_n <= 1'($random(seed));
      shadow <= 1'($random(seed));
      repeat (i == 0 ? 12 : 2) @(negedge clk_in);
      rst_n_in <= 1'b1;
      e = want(dd);
      notes.push_back(32'(proj(e)));
      repeat (3) @(negedge clk_in);
      data <= 16'($random(seed));
      ber_n <= ~ber_n;
      clk_sel <= ~clk_sel;
      if (e.rom_emu_en) notes.push_back(32'h1);
      if (e.emulator_en) notes.push_back(32'h3);
      go <= 1'b1;
      @(negedge clk_in);
      go <= 1'b0;
      repeat (2) @(negedge clk_in);
      chk(32'(respond), 32'(!e.emulator_en));
      chk(32'(csm_n), 32'h1);
      chk(32'(inhibit), 32'(e.rom_emu_en));
      repeat (8) @(negedge clk_in);
      chk(32'(proj(cfg)), 32'(proj(e)));
    end
    chk(32'(notes.size()), 32'h0);
    tally_and_finish;
  end
endmodule // reset_mode_pin_config_tb
`default_nettype wire
